// >>> verilog/pixel_pkg.sv
// shared constants and types for the pixel unpack and palette datapath
// assumes a single core clock and the configuration held steady in a frame
package pixel_pkg;

  // display type codes
  localparam logic [1:0] DISP_STN_MONO  = 2'h0;
  localparam logic [1:0] DISP_STN_COLOR = 2'h1;
  localparam logic [1:0] DISP_TFT       = 2'h2;

  // bits-per-pixel field codes
  localparam logic [2:0] BPP_1  = 3'h0;
  localparam logic [2:0] BPP_2  = 3'h1;
  localparam logic [2:0] BPP_4  = 3'h2;
  localparam logic [2:0] BPP_8  = 3'h3;
  localparam logic [2:0] BPP_16 = 3'h4;
  localparam logic [2:0] BPP_24 = 3'h5;

  // memory order codes
  localparam logic ORDER_LITTLE = 1'b0;
  localparam logic ORDER_BIG    = 1'b1;

  // palette geometry
  localparam int          PAL_ENTRIES  = 256;
  localparam logic [15:0] PAL_RESET    = 16'h0000;
  localparam int          PAL_INT_BIT  = 15;
  localparam int          PAL_BLUE_LSB = 10;
  localparam int          PAL_GRN_LSB  = 5;
  localparam int          PAL_RED_LSB  = 0;

  // positions on the lcd data bus for tft palettised output
  localparam int LCD_BLUE_LSB = 19;
  localparam int LCD_GRN_LSB  = 11;
  localparam int LCD_RED_LSB  = 3;
  localparam int LCD_INT_B    = 18;
  localparam int LCD_INT_G    = 10;
  localparam int LCD_INT_R    = 2;

  localparam logic [6:0] WORD_BITS = 7'h20;

  typedef struct packed {
    logic [1:0] display_type_select;
    logic [2:0] bits_per_pixel_field;
    logic       memory_order_select;
  } cfg_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  index;
    logic [31:0] wdata;
  } pal_req_t;

endpackage : pixel_pkg

// >>> verilog/palette_table.sv
// 256 x 16 colour lookup table held in flip-flops
// host port: one word per entry, read data registered one cycle later
`timescale 1ns/1ps
module palette_table (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire pixel_pkg::pal_req_t host_i,
  output logic [31:0]            host_rdata_o,
  input  wire logic [7:0]        pix_index_i,
  output logic [15:0]            pix_entry_o
);

  logic [15:0] mem_reg  [pixel_pkg::PAL_ENTRIES];
  logic [15:0] mem_next [pixel_pkg::PAL_ENTRIES];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    mem_next = mem_reg;
    rdata_next = rdata_reg;
    if (host_i.wr) begin
      mem_next[host_i.index] = host_i.wdata[15:0]; // R6 R8 R9
    end
    if (host_i.rd) begin
      rdata_next = {16'h0000, mem_reg[host_i.index]}; // R6 R7 R18
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < pixel_pkg::PAL_ENTRIES; i++) begin
        mem_reg[i] <= pixel_pkg::PAL_RESET;
      end
      rdata_reg <= 32'h00000000;
    end else begin
      mem_reg   <= mem_next;
      rdata_reg <= rdata_next;
    end
  end

  assign host_rdata_o = rdata_reg;
  assign pix_entry_o  = mem_reg[pix_index_i]; // R4 R5

endmodule : palette_table

// >>> verilog/lcd_pixel_unpack_palette.sv
// pixel unpacking, palette lookup and lcd data forming
// assumes words come from the controller fifo on the same core clock and
// that the configuration changes only while the stream is idle
//
// Notes on behaviour
// R1: little-endian takes pixels from bit 0 up; big-endian from bit 31 down.
// R2: pixel width 1,2,4,8,16,24 bits per field; order per order field.
// R3: palette for listed modes; bypass for tft 16/24, mono 4, colour 16.
// R4: palettised pixel bits index one of the table entries.
// R5: shade or colour comes from the indexed entry.
// R6: host writes and reads back every entry.
// R7: each entry on its own word, value in low half.
// R8: host writes full words; upper sixteen bits are ignored.
// R9: table has 256 sixteen-bit entries chosen by software.
// R10: entry is intensity 15, blue 14:10, green 9:5, red 4:0.
// R11: stn mono uses the upper four red bits.
// R12: stn colour uses upper four bits of blue, green and red.
// R13: tft uses all five bits of each colour.
// R14: tft intensity bit drives data bus bits 18, 10 and 2.
// R15: one intensity bit shared by all three components.
// R16: tft palettised drives bits 17:16, 9:8, 1:0 to zero.
// R17: non-palettised pixel bits pass straight on.
// R18: host reads return the entry in low half, zeros above.
`timescale 1ns/1ps
module lcd_pixel_unpack_palette (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire pixel_pkg::cfg_t     cfg_i,
  input  wire logic                word_valid_i,
  input  wire logic [31:0]         word_data_i,
  output logic                     word_ready_o,
  output logic                     lcd_valid_o,
  input  wire logic                lcd_ready_i,
  output logic [23:0]              lcd_data_bus_o,
  input  wire pixel_pkg::pal_req_t pal_req_i,
  output logic [31:0]              pal_rdata_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [6:0] pixel_bits(input logic [2:0] code);
    case (code)
      pixel_pkg::BPP_1:  pixel_bits = 7'h01;
      pixel_pkg::BPP_2:  pixel_bits = 7'h02;
      pixel_pkg::BPP_4:  pixel_bits = 7'h04;
      pixel_pkg::BPP_8:  pixel_bits = 7'h08;
      pixel_pkg::BPP_16: pixel_bits = 7'h10;
      default:           pixel_bits = 7'h18;
    endcase
  endfunction : pixel_bits

  function automatic logic is_palettised(input pixel_pkg::cfg_t c);
    logic low;
    low = (c.bits_per_pixel_field <= pixel_pkg::BPP_8);
    case (c.display_type_select)
      pixel_pkg::DISP_TFT:       is_palettised = low; // R3
      pixel_pkg::DISP_STN_COLOR: is_palettised = low; // R3
      pixel_pkg::DISP_STN_MONO:
        is_palettised = (c.bits_per_pixel_field <= pixel_pkg::BPP_2); // R3
      default:                   is_palettised = 1'b0;
    endcase
  endfunction : is_palettised

  ////////////////////////////////////////////////////////////////////////////
  // serializer: 64-bit bit buffer, fill level in bits

  logic [63:0] buf_reg;
  logic [63:0] buf_next;
  logic [6:0]  cnt_reg;
  logic [6:0]  cnt_next;
  logic        ready_reg;
  logic        ready_next;
  logic        pix_valid_reg;
  logic        pix_valid_next;
  logic [23:0] pix_reg;
  logic [23:0] pix_next;
  logic [6:0]  size;
  logic        advance;
  logic [23:0] pix_mask;
  logic [63:0] word_le;
  logic [63:0] word_be;

  assign size     = pixel_bits(cfg_i.bits_per_pixel_field); // R2
  assign advance  = !lcd_valid_o || lcd_ready_i;
  assign pix_mask = 24'hFFFFFF >> (7'h18 - size);
  assign word_le  = {32'h00000000, word_data_i} << cnt_reg;
  assign word_be  = {word_data_i, 32'h00000000} >> cnt_reg;

  // one action a cycle, either emit a pixel or take a word; costs a cycle
  // per word but keeps the buffer bounded to 24 + 32 bits
  always_comb begin
    buf_next       = buf_reg;
    cnt_next       = cnt_reg;
    pix_next       = pix_reg;
    pix_valid_next = pix_valid_reg;
    if (advance) begin
      pix_valid_next = 1'b0;
    end
    if (cnt_reg >= size) begin
      if (!pix_valid_reg || advance) begin
        pix_valid_next = 1'b1;
        cnt_next       = cnt_reg - size;
        if (cfg_i.memory_order_select == pixel_pkg::ORDER_LITTLE) begin
          pix_next = buf_reg[23:0] & pix_mask; // R1
          buf_next = buf_reg >> size;          // R1
        end else begin
          pix_next = buf_reg[63:40] >> (7'h18 - size); // R1
          buf_next = buf_reg << size;                  // R1
        end
      end
    end else if (word_valid_i && ready_reg) begin
      // words append behind leftovers so 24-bit pixels straddle words
      cnt_next = cnt_reg + pixel_pkg::WORD_BITS; // R1
      if (cfg_i.memory_order_select == pixel_pkg::ORDER_LITTLE) begin
        buf_next = buf_reg | word_le; // R1
      end else begin
        buf_next = buf_reg | word_be; // R1
      end
    end
    ready_next = (cnt_next < size);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      buf_reg       <= 64'h0000000000000000;
      cnt_reg       <= 7'h00;
      ready_reg     <= 1'b0;
      pix_valid_reg <= 1'b0;
      pix_reg       <= 24'h000000;
    end else begin
      buf_reg       <= buf_next;
      cnt_reg       <= cnt_next;
      ready_reg     <= ready_next;
      pix_valid_reg <= pix_valid_next;
      pix_reg       <= pix_next;
    end
  end

  assign word_ready_o = ready_reg;

  ////////////////////////////////////////////////////////////////////////////
  // palette lookup

  logic [15:0] entry;
  logic [4:0]  red;
  logic [4:0]  green;
  logic [4:0]  blue;
  logic        intensity;

  palette_table u_palette (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .host_i       (pal_req_i),
    .host_rdata_o (pal_rdata_o),
    .pix_index_i  (pix_reg[7:0]), // R4
    .pix_entry_o  (entry)
  );

  assign intensity = entry[pixel_pkg::PAL_INT_BIT];       // R10
  assign blue      = entry[pixel_pkg::PAL_BLUE_LSB +: 5]; // R10
  assign green     = entry[pixel_pkg::PAL_GRN_LSB +: 5];  // R10
  assign red       = entry[pixel_pkg::PAL_RED_LSB +: 5];  // R10

  ////////////////////////////////////////////////////////////////////////////
  // output forming

  logic        out_valid_reg;
  logic        out_valid_next;
  logic [23:0] out_reg;
  logic [23:0] out_next;
  logic [23:0] formed;

  always_comb begin
    formed = 24'h000000;
    if (!is_palettised(cfg_i)) begin
      formed = pix_reg; // R17
    end else begin
      case (cfg_i.display_type_select)
        pixel_pkg::DISP_TFT: begin
          // unused low bits stay zero from the default above
          formed[pixel_pkg::LCD_BLUE_LSB +: 5] = blue;  // R13 R16
          formed[pixel_pkg::LCD_GRN_LSB +: 5]  = green; // R13 R16
          formed[pixel_pkg::LCD_RED_LSB +: 5]  = red;   // R13 R16
          formed[pixel_pkg::LCD_INT_B] = intensity;     // R14 R15
          formed[pixel_pkg::LCD_INT_G] = intensity;     // R14 R15
          formed[pixel_pkg::LCD_INT_R] = intensity;     // R14 R15
        end
        pixel_pkg::DISP_STN_COLOR: begin
          formed[11:0] = {blue[4:1], green[4:1], red[4:1]}; // R12 R5
        end
        default: begin
          formed[3:0] = red[4:1]; // R11 R5
        end
      endcase
    end
  end

  always_comb begin
    out_valid_next = out_valid_reg;
    out_next       = out_reg;
    if (advance) begin
      out_valid_next = pix_valid_reg;
      if (pix_valid_reg) begin
        out_next = formed;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_valid_reg <= 1'b0;
      out_reg       <= 24'h000000;
    end else begin
      out_valid_reg <= out_valid_next;
      out_reg       <= out_next;
    end
  end

  assign lcd_valid_o    = out_valid_reg;
  assign lcd_data_bus_o = out_reg;

endmodule : lcd_pixel_unpack_palette

// >>> bench/lcd_pixel_unpack_palette_chk.sv
// port assertions for the pixel unpack and palette datapath
// assumes a bind onto lcd_pixel_unpack_palette, one clock domain
`timescale 1ns/1ps
module lcd_pixel_unpack_palette_chk (
  input wire logic                clk_i,
  input wire logic                reset_i,
  input wire pixel_pkg::cfg_t     cfg_i,
  input wire logic                word_valid_i,
  input wire logic [31:0]         word_data_i,
  input wire logic                word_ready_o,
  input wire logic                lcd_valid_o,
  input wire logic                lcd_ready_i,
  input wire logic [23:0]         lcd_data_bus_o,
  input wire pixel_pkg::pal_req_t pal_req_i,
  input wire logic [31:0]         pal_rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire [1:0] dt       = cfg_i.display_type_select;
  wire [2:0] bp       = cfg_i.bits_per_pixel_field;
  wire       tft_pal  = lcd_valid_o && dt == pixel_pkg::DISP_TFT
                        && bp <= pixel_pkg::BPP_8;
  wire       mono_pal = lcd_valid_o && dt == pixel_pkg::DISP_STN_MONO
                        && bp <= pixel_pkg::BPP_2;
  wire       col_pal  = lcd_valid_o && dt == pixel_pkg::DISP_STN_COLOR
                        && bp <= pixel_pkg::BPP_8;
  sequence s_take;
    word_valid_i && word_ready_o;
  endsequence
  // a read right behind a write must already see the new entry
  sequence s_wr_rd;
    pal_req_i.wr ##1 pal_req_i.rd && !pal_req_i.wr
      && pal_req_i.index == $past(pal_req_i.index);
  endsequence
  ////////////////////////////////////////////////////////////
  chk_take_drops: assert property (
    s_take |=> !word_ready_o ##[1:40] lcd_valid_o) else $error("no pixel");
  chk_stall_hold: assert property (
    lcd_valid_o && !lcd_ready_i |=> lcd_valid_o && $stable(lcd_data_bus_o))
    else $error("pixel lost in stall");
  chk_rd_upper: assert property (
    pal_req_i.rd |=> pal_rdata_o[31:16] == 16'h0000) else $error("upper");
  chk_rd_hold: assert property (
    !pal_req_i.rd |=> $stable(pal_rdata_o)) else $error("read data moved");
  chk_wr_rd: assert property (
    s_wr_rd |=> pal_rdata_o[15:0] == $past(pal_req_i.wdata[15:0], 2))
    else $error("entry not written");
  chk_tft_zero: assert property (
    tft_pal |-> (lcd_data_bus_o & 24'h03_0303) == 24'h00_0000)
    else $error("unused lines set");
  chk_tft_int: assert property (
    tft_pal |-> lcd_data_bus_o[18] == lcd_data_bus_o[10]
      && lcd_data_bus_o[10] == lcd_data_bus_o[2]) else $error("intensity");
  chk_mono_width: assert property (
    mono_pal |-> lcd_data_bus_o[23:4] == 20'h00000) else $error("mono");
  chk_colour_width: assert property (
    col_pal |-> lcd_data_bus_o[23:12] == 12'h000) else $error("colour");
endmodule : lcd_pixel_unpack_palette_chk

// >>> bench/lcd_sink_model.sv
// downstream sink standing for shifter and panel
// assumes one core clock; ready changes at the falling edge
`timescale 1ns/1ps
module lcd_sink_model (
  input  wire logic clk_i,
  input  wire logic stall_en_i,
  output logic      lcd_ready_o
);
  integer seed = 32'h4766;
  // single driver; ready is unknown only while reset is still held
  // random back-pressure, else the data hold is never exercised
  always @(negedge clk_i) begin
    lcd_ready_o <= !stall_en_i || ($random(seed) & 3) != 0;
  end
endmodule : lcd_sink_model

// >>> bench/lcd_pixel_unpack_palette_tb.sv
// self-checking bench for the pixel unpack and palette datapath
// assumes the checker and sink model are compiled before it
`timescale 1ns/1ps
module lcd_pixel_unpack_palette_tb;
  logic                clk_i        = 1'b0;
  logic                reset_i      = 1'b1;
  logic                word_valid_i = 1'b0;
  logic                stall_en     = 1'b0;
  logic [31:0]         word_data_i  = 32'h0;
  pixel_pkg::cfg_t     cfg_i        = '0;
  pixel_pkg::pal_req_t pal_req_i    = '0;
  logic                lcd_ready_i, word_ready_o, lcd_valid_o;
  logic [23:0]         lcd_data_bus_o;
  logic [31:0]         pal_rdata_o;
  logic [15:0]         pal [256];
  logic [23:0]         exp_q [$];
  logic [63:0]         acc;
  int                  nbits, num_errors = 0, comparisons = 0;
  integer              seed = 32'h4766;
  int                  sz [6] = '{1, 2, 4, 8, 16, 24};
  wire [1:0]           dt = cfg_i.display_type_select;
  wire [2:0]           bp = cfg_i.bits_per_pixel_field;
  always #20 clk_i = ~clk_i;
  lcd_pixel_unpack_palette i_dut (.clk_i, .reset_i, .cfg_i, .word_valid_i,
    .word_data_i, .word_ready_o, .lcd_valid_o, .lcd_ready_i,
    .lcd_data_bus_o, .pal_req_i, .pal_rdata_o);
  lcd_sink_model i_sink (.clk_i, .stall_en_i(stall_en),
    .lcd_ready_o(lcd_ready_i));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  function automatic logic [23:0] form(input logic [23:0] p);
    logic [15:0] e;
    e = pal[p[7:0]];
    if (dt == pixel_pkg::DISP_TFT && bp <= pixel_pkg::BPP_8)
      return {e[14:10], e[15], 2'h0, e[9:5], e[15], 2'h0, e[4:0], e[15], 2'h0};
    if (dt == pixel_pkg::DISP_STN_COLOR && bp <= pixel_pkg::BPP_8)
      return {12'h000, e[14:11], e[9:6], e[4:1]};
    if (dt == pixel_pkg::DISP_STN_MONO && bp <= pixel_pkg::BPP_2)
      return {20'h00000, e[4:1]};
    return p;
  endfunction : form
  // bit stream model; leftover bits carry into the next word
  task automatic send_word(input logic [31:0] w);
    int n, k;
    n = sz[bp];
    if (cfg_i.memory_order_select == pixel_pkg::ORDER_BIG)
      acc = {acc[31:0], w};
    else
      acc = acc | ({32'h0, w} << nbits);
    nbits += 32;
    while (nbits >= n) begin
      if (cfg_i.memory_order_select == pixel_pkg::ORDER_BIG)
        exp_q.push_back(form(24'((acc >> (nbits - n)) & ((64'h1 << n) - 1))));
      else begin
        exp_q.push_back(form(24'(acc & ((64'h1 << n) - 1))));
        acc = acc >> n;
      end
      nbits -= n;
    end
    @(negedge clk_i);
    word_valid_i = 1'b1;
    word_data_i = w;
    for (k = 0; k < 200 && word_ready_o !== 1'b1; k++) @(negedge clk_i);
    @(negedge clk_i);
    word_valid_i = 1'b0;
  endtask : send_word
  always @(posedge clk_i) begin
    if (!reset_i && lcd_valid_o === 1'b1 && lcd_ready_i)
      check(lcd_data_bus_o, exp_q.pop_front());
  end
  initial begin
    repeat (10) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    check(pal_rdata_o, 32'h0);
    for (int i = 0; i < 256; i++) begin
      @(negedge clk_i);
      pal[i] = 16'($random(seed));
      pal_req_i = '{wr: 1'b1, rd: 1'b0, index: 8'(i),
                    wdata: {16'($random(seed)), pal[i]}};
    end
    for (int i = 255; i >= 0; i--) begin
      @(negedge clk_i);
      if (i < 255) check(pal_rdata_o, {16'h0, pal[i + 1]});
      pal_req_i = '{wr: 1'b0, rd: 1'b1, index: 8'(i), wdata: 32'h0};
    end
    @(negedge clk_i);
    check(pal_rdata_o, {16'h0, pal[0]});
    pal_req_i = '0;
    for (int c = 0; c < 36; c++) begin
      cfg_i = '{display_type_select: 2'(c / 12), bits_per_pixel_field:
                3'(c % 6), memory_order_select: 1'(c / 6 % 2)};
      stall_en = c[0];
      acc = '0;
      nbits = 0;
      for (int k = 0; k < 3; k++)
        send_word(k == 0 ? 32'h8000_0001 : $random(seed));
      for (int t = 0; t < 400 && exp_q.size() > 0; t++) @(negedge clk_i);
      repeat (4) @(negedge clk_i);
      check(word_ready_o, 32'h1);
    end
    check(exp_q.size(), 32'h0);
    summarize();
  end
  // whole run is near 2300 cycles; 50000 means a hang
  initial begin
    #2_000_000;
    num_errors++;
    summarize();
  end
endmodule : lcd_pixel_unpack_palette_tb
bind lcd_pixel_unpack_palette lcd_pixel_unpack_palette_chk i_chk (.clk_i,
  .reset_i, .cfg_i, .word_valid_i, .word_data_i, .word_ready_o,
  .lcd_valid_o, .lcd_ready_i, .lcd_data_bus_o, .pal_req_i, .pal_rdata_o);
